// File: hdl/aiobt_pkg.sv
// shared constants and carriers for the automatic block transfer engine
package aiobt_pkg;
    // operation kinds carried in the start request
    typedef enum logic [1:0] {
        AIOBT_IN_BYTE,
        AIOBT_IN_WORD,
        AIOBT_OUT_BYTE,
        AIOBT_OUT_WORD
    } aiobt_kind_type;

    localparam int AIOBT_AW = 16;
    localparam int AIOBT_DW = 16;
    // device field split: upper five bits address, lower three function
    localparam int AIOBT_DEV_LSB = 3;
    localparam int AIOBT_DEV_W = 5;
    localparam int AIOBT_FUNC_W = 3;
    // offsets of the instruction's parameter words and exits from p
    localparam logic [15:0] AIOBT_OFS_CNT = 16'h0001;
    localparam logic [15:0] AIOBT_OFS_PTR = 16'h0002;
    localparam logic [15:0] AIOBT_OFS_EOB = 16'h0003;
    localparam logic [15:0] AIOBT_OFS_NEXT = 16'h0004;
    // peripheral data cycle length
    localparam int AIOBT_CLK_NS = 20;
    localparam int AIOBT_IO_CYCLE_NS = 80;
    localparam int AIOBT_IO_CYCLES = (AIOBT_IO_CYCLE_NS + AIOBT_CLK_NS - 1) / AIOBT_CLK_NS;
    localparam logic [3:0] AIOBT_IO_LAST = 4'(AIOBT_IO_CYCLES - 1);
    localparam int AIOBT_FIFO_DEPTH = 32;
    localparam logic ECHO_IDLE = 1'b1;

    // one instruction handed over by the processor sequencer
    typedef struct packed {
        aiobt_kind_type kind;
        logic [7:0] dev;
        logic [15:0] p;
        logic intr;
        logic [15:0] ret_p;
    } aiobt_start_type;

    // memory request as seen on the memory port
    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [1:0] be;
        logic [15:0] wdata;
    } aiobt_mem_type;
endpackage : aiobt_pkg

// File: hdl/aiobt_top.sv
// automatic i/o block transfer engine with its data fifo
`timescale 1ns/1ns
`default_nettype none

// small first-in first-out buffer in the data path
module aiobt_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wr_ff;
    logic [AW:0] rd_ff;
    logic push;
    logic pop;

    // extra pointer bit tells full from empty
    assign o_in_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
    assign o_out_valid = wr_ff != rd_ff;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem_ff[rd_ff[AW-1:0]];

    // storage, no reset needed on the array
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_ff[wr_ff[AW-1:0]] <= i_in_data;
        end
    end

    // pointers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= wr_ff + (AW+1)'(1);
            end
            if (pop) begin
                rd_ff <= rd_ff + (AW+1)'(1);
            end
        end
    end
endmodule : aiobt_fifo

// How it works
// - second word is a negative count, incremented before every transfer
// - third word is start minus one, incremented, then used as data address
// - in line with count nonzero afterwards, continue at p plus four
// - in line with count now zero, continue at p plus three
// - transfer runs without asking the peripheral whether it is ready
// - one interrupt to the instruction gives exactly one execution
// - no processor register is touched by these operations
// - under interrupt no skip, return to the interrupted program point
// - under interrupt with count zero, send end-of-block notify to peripheral
// - under interrupt return happens whether or not notify was sent
// - byte input moves one 8-bit byte from peripheral into memory byte
// - word input moves one 16-bit word from peripheral into memory word
// - byte output moves one 8-bit memory byte to the peripheral
// - word output moves one 16-bit memory word to the peripheral
// - device field: upper five bits peripheral address, lower three function
module aiobt_top
    import aiobt_pkg::*;
#(
    parameter int FIFO_DEPTH = AIOBT_FIFO_DEPTH
) (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_START_VALID,
    input wire aiobt_start_type I_START,
    output logic O_START_READY,
    output aiobt_mem_type O_MEM,
    input wire logic I_MEM_ACK,
    input wire logic [15:0] I_MEM_RDATA,
    output logic [4:0] O_IO_DEV,
    output logic [2:0] O_IO_FUNC,
    output logic O_IO_RD,
    output logic O_IO_WR,
    output logic [15:0] O_IO_DOUT,
    input wire logic [15:0] I_IO_DIN,
    output logic O_ECHO_N,
    output logic O_DONE,
    output logic [15:0] O_NEXT_P
);
    typedef enum logic [2:0] {
        S_IDLE,
        S_RD_CNT,
        S_RD_PTR,
        S_WR_CNT,
        S_WR_PTR,
        S_SRC,
        S_DST,
        S_DONE
    } aiobt_state_type;

    aiobt_state_type state_ff;
    aiobt_state_type nxt_state;
    aiobt_start_type op_ff;
    logic [15:0] cnt_ff;
    logic [15:0] ptr_ff;
    logic [3:0] io_cnt_ff;
    logic io_busy_ff;
    logic [15:0] din_meta_ff;
    logic [15:0] din_sync_ff;
    logic [15:0] io_dout_ff;
    logic io_rd_ff;
    logic io_wr_ff;
    logic echo_n_ff;
    logic done_ff;
    logic [15:0] next_p_ff;
    logic is_out;
    logic is_byte;
    logic io_phase;
    logic io_last;
    logic src_ok;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [15:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [15:0] fifo_out_data;
    logic dst_ok;

    // byte pointers address half words: even byte is the upper half
    function automatic logic [15:0] data_addr(input logic byte_mode, input logic [15:0] ptr);
        data_addr = byte_mode ? {1'b0, ptr[15:1]} : ptr;
    endfunction : data_addr

    function automatic logic [1:0] lane_be(input logic byte_mode, input logic [15:0] ptr);
        lane_be = !byte_mode ? 2'h3 : (ptr[0] ? 2'h1 : 2'h2);
    endfunction : lane_be

    assign is_out = (op_ff.kind == AIOBT_OUT_BYTE) || (op_ff.kind == AIOBT_OUT_WORD);
    assign is_byte = (op_ff.kind == AIOBT_IN_BYTE) || (op_ff.kind == AIOBT_OUT_BYTE);
    assign O_START_READY = (state_ff == S_IDLE);
    // the peripheral cycle is in the source state for input, destination for output
    assign io_phase = is_out ? (state_ff == S_DST) : (state_ff == S_SRC);
    assign io_last = io_busy_ff && (io_cnt_ff == AIOBT_IO_LAST);

    // pin data passes two flops before anything looks at it; no reset, since
    // the value is only read at the end of a strobe that outlasts both stages
    always_ff @(posedge I_CLK) begin
        din_meta_ff <= I_IO_DIN;
        din_sync_ff <= din_meta_ff;
    end

    // memory port: requests are a handshake held until acknowledged
    always_comb begin
        O_MEM = '0;
        case (state_ff)
            S_RD_CNT, S_RD_PTR, S_WR_CNT, S_WR_PTR: begin
                // parameter words: count at p+1, pointer at p+2, read then written back
                O_MEM.req = 1'b1;
                O_MEM.we = (state_ff == S_WR_CNT) || (state_ff == S_WR_PTR);
                O_MEM.be = O_MEM.we ? 2'h3 : 2'h0;
                if ((state_ff == S_RD_CNT) || (state_ff == S_WR_CNT)) begin
                    O_MEM.addr = op_ff.p + AIOBT_OFS_CNT;
                    O_MEM.wdata = O_MEM.we ? cnt_ff : 16'h0000;
                end else begin
                    O_MEM.addr = op_ff.p + AIOBT_OFS_PTR;
                    O_MEM.wdata = O_MEM.we ? ptr_ff : 16'h0000;
                end
            end
            S_SRC: begin
                // output kinds read the buffer, waiting for fifo room first
                O_MEM.req = is_out && fifo_in_ready;
                O_MEM.addr = data_addr(is_byte, ptr_ff);
            end
            S_DST: begin
                // input kinds write the buffer from the fifo head
                O_MEM.req = !is_out && fifo_out_valid;
                O_MEM.we = 1'b1;
                O_MEM.addr = data_addr(is_byte, ptr_ff);
                O_MEM.be = lane_be(is_byte, ptr_ff);
                O_MEM.wdata = is_byte ? {2{fifo_out_data[7:0]}} : fifo_out_data;
            end
            default: begin
                O_MEM = '0;
            end
        endcase
    end

    // fifo feed: memory word or lane for output, synced pin data for input
    always_comb begin
        fifo_in_valid = 1'b0;
        fifo_in_data = 16'h0000;
        if (state_ff == S_SRC) begin
            if (is_out) begin
                fifo_in_valid = I_MEM_ACK;
                fifo_in_data = !is_byte ? I_MEM_RDATA :
                    {8'h00, ptr_ff[0] ? I_MEM_RDATA[7:0] : I_MEM_RDATA[15:8]};
            end else begin
                fifo_in_valid = io_last;
                fifo_in_data = is_byte ? {8'h00, din_sync_ff[7:0]} : din_sync_ff;
            end
        end
    end

    assign src_ok = fifo_in_valid && fifo_in_ready;
    assign fifo_out_ready = (state_ff == S_DST) && (is_out ? io_last : I_MEM_ACK);
    assign dst_ok = fifo_out_ready && fifo_out_valid;

    aiobt_fifo #(
        .WIDTH(AIOBT_DW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fifo_in_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out_data)
    );

    // sequencer; the engine has no path to the accumulator or index
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: begin
                if (I_START_VALID) begin
                    nxt_state = S_RD_CNT;
                end
            end
            S_RD_CNT: begin
                if (I_MEM_ACK) begin
                    nxt_state = S_RD_PTR;
                end
            end
            S_RD_PTR: begin
                if (I_MEM_ACK) begin
                    nxt_state = S_WR_CNT;
                end
            end
            S_WR_CNT: begin
                if (I_MEM_ACK) begin
                    nxt_state = S_WR_PTR;
                end
            end
            S_WR_PTR: begin
                if (I_MEM_ACK) begin
                    nxt_state = S_SRC; // no readiness test before moving data
                end
            end
            S_SRC: begin
                if (src_ok) begin
                    nxt_state = S_DST;
                end
            end
            S_DST: begin
                if (dst_ok) begin
                    nxt_state = S_DONE;
                end
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            state_ff <= S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // instruction capture, one execution per accepted request
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            op_ff <= '0;
        end else if (state_ff == S_IDLE && I_START_VALID) begin
            op_ff <= I_START;
        end
    end

    // counter and pointer are bumped as they are read in
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            cnt_ff <= 16'h0000;
            ptr_ff <= 16'h0000;
        end else begin
            if (state_ff == S_RD_CNT && I_MEM_ACK) begin
                cnt_ff <= I_MEM_RDATA + 16'h0001;
            end
            if (state_ff == S_RD_PTR && I_MEM_ACK) begin
                ptr_ff <= I_MEM_RDATA + 16'h0001;
            end
        end
    end

    // peripheral cycle timer and strobes; address and function from the device field
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            io_busy_ff <= 1'b0;
            io_cnt_ff <= 4'h0;
            io_rd_ff <= 1'b0;
            io_wr_ff <= 1'b0;
            echo_n_ff <= ECHO_IDLE;
        end else if (io_phase && !io_busy_ff && (is_out ? fifo_out_valid : fifo_in_ready)) begin
            io_busy_ff <= 1'b1;
            io_cnt_ff <= 4'h0;
            io_rd_ff <= !is_out;
            io_wr_ff <= is_out;
            // notify only in the final transfer of an interrupt run
            echo_n_ff <= !(op_ff.intr && cnt_ff == 16'h0000);
        end else if (io_last) begin
            io_busy_ff <= 1'b0;
            io_rd_ff <= 1'b0;
            io_wr_ff <= 1'b0;
            echo_n_ff <= ECHO_IDLE;
        end else if (io_busy_ff) begin
            io_cnt_ff <= io_cnt_ff + 4'h1;
        end
    end

    // output data latched from the fifo head at the start of the cycle
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            io_dout_ff <= 16'h0000;
        end else if (state_ff == S_DST && is_out && !io_busy_ff && fifo_out_valid) begin
            io_dout_ff <= is_byte ? {8'h00, fifo_out_data[7:0]} : fifo_out_data;
        end
    end

    assign O_IO_DEV = op_ff.dev[AIOBT_DEV_LSB +: AIOBT_DEV_W];
    assign O_IO_FUNC = op_ff.dev[AIOBT_FUNC_W-1:0];
    assign O_IO_RD = io_rd_ff;
    assign O_IO_WR = io_wr_ff;
    assign O_IO_DOUT = io_dout_ff;
    assign O_ECHO_N = echo_n_ff;
    assign O_DONE = done_ff;
    assign O_NEXT_P = next_p_ff;

    // completion with the next program address
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            done_ff <= 1'b0;
            next_p_ff <= 16'h0000;
        end else begin
            done_ff <= (state_ff == S_DST) && dst_ok;
            if ((state_ff == S_DST) && dst_ok) begin
                if (op_ff.intr) begin
                    next_p_ff <= op_ff.ret_p;
                end else if (cnt_ff == 16'h0000) begin
                    next_p_ff <= op_ff.p + AIOBT_OFS_EOB;
                end else begin
                    next_p_ff <= op_ff.p + AIOBT_OFS_NEXT;
                end
            end
        end
    end
endmodule : aiobt_top
`default_nettype wire

// File: tb/aiobt_top_assertions.sv
// port-level checks of the block transfer engine
`timescale 1ns/1ns
`default_nettype none
module aiobt_top_assertions
    import aiobt_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_START_VALID,
    input wire aiobt_start_type I_START,
    input wire logic O_START_READY,
    input wire aiobt_mem_type O_MEM,
    input wire logic I_MEM_ACK,
    input wire logic [4:0] O_IO_DEV,
    input wire logic [2:0] O_IO_FUNC,
    input wire logic O_IO_RD,
    input wire logic O_IO_WR,
    input wire logic O_ECHO_N,
    input wire logic O_DONE,
    input wire logic [15:0] O_NEXT_P
);
    logic io;
    logic take;
    logic [7:0] dev_ff;
    logic intr_ff;
    logic [15:0] ret_ff;
    assign io = O_IO_RD | O_IO_WR;
    assign take = I_START_VALID & O_START_READY;
    // remember the accepted request for checks at the end of the run
    always_ff @(posedge I_CLK) begin
        if (take) begin
            dev_ff <= I_START.dev;
            intr_ff <= I_START.intr;
            ret_ff <= I_START.ret_p;
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);
    // one peripheral cycle is four clocks, then the strobe drops
    sequence io_burst;
        io [*4] ##1 !io;
    endsequence
    sequence notify_burst;
        !O_ECHO_N [*4] ##1 O_ECHO_N;
    endsequence
    a_echo_in_io: assert property (!O_ECHO_N |-> io)
        else $error("notify outside io cycle");
    a_echo_whole: assert property ($fell(O_ECHO_N) |-> notify_burst)
        else $error("notify length wrong");
    a_io_length: assert property ($rose(io) |-> io_burst)
        else $error("io cycle length wrong");
    a_rd_wr_excl: assert property (!(O_IO_RD && O_IO_WR))
        else $error("read and write together");
    a_done_after: assert property ($fell(io) |-> ##[0:3] O_DONE)
        else $error("no done after io");
    a_one_done: assert property (O_DONE |=> !O_DONE)
        else $error("done longer than one cycle");
    a_busy_taken: assert property (take |=> !O_START_READY)
        else $error("ready while busy");
    a_count_first: assert property (take |=> O_MEM.req && !O_MEM.we
        && O_MEM.addr == $past(I_START.p) + AIOBT_OFS_CNT) else $error("first read not count");
    a_mem_hold: assert property (O_MEM.req && !I_MEM_ACK |=>
        O_MEM.req && $stable(O_MEM)) else $error("memory request dropped");
    a_dev_field: assert property (io |-> {O_IO_DEV, O_IO_FUNC} == dev_ff)
        else $error("device field split wrong");
    a_intr_return: assert property (O_DONE && intr_ff |-> O_NEXT_P == ret_ff)
        else $error("interrupt return wrong");
endmodule : aiobt_top_assertions

bind aiobt_top aiobt_top_assertions u_chk (.I_CLK(I_CLK), .I_SRST(I_SRST),
    .I_START_VALID(I_START_VALID), .I_START(I_START), .O_START_READY(O_START_READY),
    .O_MEM(O_MEM), .I_MEM_ACK(I_MEM_ACK), .O_IO_DEV(O_IO_DEV), .O_IO_FUNC(O_IO_FUNC),
    .O_IO_RD(O_IO_RD), .O_IO_WR(O_IO_WR), .O_ECHO_N(O_ECHO_N), .O_DONE(O_DONE),
    .O_NEXT_P(O_NEXT_P));
`default_nettype wire

// File: tb/aiobt_periph_model.sv
// peripheral controller model on the far side of the io port
`timescale 1ns/1ns
`default_nettype none
module aiobt_periph_model #(
    parameter logic [15:0] XFER_VEC = 16'h0000
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_arm,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic i_echo_n,
    input wire logic [4:0] i_dev,
    input wire logic [2:0] i_func,
    input wire logic [15:0] i_dout,
    input wire logic [15:0] i_data,
    output logic [15:0] o_din,
    output logic o_req,
    output logic o_eob,
    output logic [15:0] o_wdata,
    output logic [7:0] o_devsel,
    output logic [15:0] o_eob_vec,
    output int o_echo_cycles
);
    logic [15:0] junk_ff;
    logic stop_ff;
    // released bus flips every cycle so stale data never looks valid
    always_ff @(posedge i_clk) begin
        junk_ff <= i_srst ? 16'h5a5a : ~junk_ff;
    end
    assign o_din = i_rd ? i_data : junk_ff;
    // capture what the engine presents during its io cycle
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_echo_cycles <= 0;
            o_devsel <= 8'h00;
        end else begin
            if (i_wr) o_wdata <= i_dout;
            if (i_rd | i_wr) o_devsel <= {i_dev, i_func};
            if (!i_echo_n) o_echo_cycles <= o_echo_cycles + 1;
        end
    end
    // request transfers until notified, then close the block
    always_ff @(posedge i_clk) begin
        if (i_srst || i_arm) begin
            o_req <= i_arm;
            stop_ff <= 1'b0;
            o_eob <= 1'b0;
            o_eob_vec <= 16'h0000;
        end else if (!i_echo_n) begin
            o_req <= 1'b0;
            stop_ff <= 1'b1;
        end else if (stop_ff) begin
            o_eob <= 1'b1;
            // customary placement: four past the transfer location
            o_eob_vec <= XFER_VEC + 16'h0004;
            stop_ff <= 1'b0;
        end
    end
endmodule : aiobt_periph_model
`default_nettype wire

// File: tb/tb_auto_io_block_transfer.sv
// self-checking bench for the block transfer engine
`timescale 1ns/1ns
`default_nettype none
module tb_auto_io_block_transfer import aiobt_pkg::*; ();
    logic clk, srst, start_valid, start_ready, mem_ack, io_rd, io_wr, echo_n, done;
    logic arm, per_req, per_eob;
    aiobt_start_type start;
    aiobt_mem_type mem_bus;
    logic [15:0] mem_rdata, io_dout, io_din, io_data, next_p, per_wdata, eob_vec;
    logic nxt_ack;
    int stall = 0;
    logic [4:0] io_dev;
    logic [2:0] io_func;
    logic [7:0] per_dev;
    logic [15:0] mem [0:65535];
    int echo_cycles, n;
    int miscompares = 0;
    int samples_checked = 0;
    int cyc = 0;
    aiobt_top uut (.I_CLK(clk), .I_SRST(srst), .I_START_VALID(start_valid), .I_START(start),
        .O_START_READY(start_ready), .O_MEM(mem_bus), .I_MEM_ACK(mem_ack),
        .I_MEM_RDATA(mem_rdata), .O_IO_DEV(io_dev), .O_IO_FUNC(io_func), .O_IO_RD(io_rd),
        .O_IO_WR(io_wr), .O_IO_DOUT(io_dout), .I_IO_DIN(io_din), .O_ECHO_N(echo_n),
        .O_DONE(done), .O_NEXT_P(next_p));
    aiobt_periph_model #(.XFER_VEC(16'ha000)) u_per (.i_clk(clk), .i_srst(srst), .i_arm(arm),
        .i_rd(io_rd), .i_wr(io_wr), .i_echo_n(echo_n), .i_dev(io_dev), .i_func(io_func),
        .i_dout(io_dout), .i_data(io_data), .o_din(io_din), .o_req(per_req), .o_eob(per_eob),
        .o_wdata(per_wdata), .o_devsel(per_dev), .o_eob_vec(eob_vec),
        .o_echo_cycles(echo_cycles));
    initial clk = 1'b0;
    always #10 clk = ~clk;
    // memory with random acknowledge stalls, never more than two in a row so
    // the done-after-io bound holds; writes land at the acking edge
    always @(posedge clk) begin
        if (mem_bus.req && mem_ack && mem_bus.we) begin
            if (mem_bus.be[1]) mem[mem_bus.addr][15:8] = mem_bus.wdata[15:8];
            if (mem_bus.be[0]) mem[mem_bus.addr][7:0] = mem_bus.wdata[7:0];
        end
        #1;
        nxt_ack = mem_bus.req && (stall == 2 || $urandom_range(3) != 0);
        stall <= (mem_bus.req && !nxt_ack) ? stall + 1 : 0;
        mem_ack <= nxt_ack;
        mem_rdata <= mem_bus.req ? mem[mem_bus.addr] : ~mem_rdata;
    end
    // hang guard, far above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp
    function automatic logic [15:0] exp_next(input logic intr, input logic [15:0] p, ret, cnt);
        if (intr) return ret;
        return (cnt == 16'hffff) ? p + AIOBT_OFS_EOB : p + AIOBT_OFS_NEXT;
    endfunction : exp_next
    // even byte address is the upper half of the word
    function automatic logic [15:0] exp_data(input aiobt_kind_type k,
        input logic [15:0] np, old, din);
        case (k)
            AIOBT_IN_BYTE: return np[0] ? {old[15:8], din[7:0]} : {din[7:0], old[7:0]};
            AIOBT_IN_WORD: return din;
            AIOBT_OUT_BYTE: return {8'h00, np[0] ? old[7:0] : old[15:8]};
            default: return old;
        endcase
    endfunction : exp_data
    task automatic run_op(input aiobt_kind_type k, input logic intr,
        input logic [15:0] p, cnt, ptr);
        logic [15:0] np, w, old, ret;
        logic [7:0] dev;
        int e0;
        np = ptr + 16'h0001;
        w = k[0] ? np : np >> 1;
        old = 16'($urandom);
        ret = 16'($urandom);
        dev = 8'($urandom);
        mem[p + 16'h0001] = cnt;
        mem[p + 16'h0002] = ptr;
        mem[w] = old;
        io_data = 16'($urandom);
        e0 = echo_cycles;
        start = '{kind: k, dev: dev, p: p, intr: intr, ret_p: ret};
        start_valid = 1'b1;
        @(posedge clk);
        while (start_ready !== 1'b1) @(posedge clk);
        #1;
        start_valid = 1'b0;
        for (int i = 0; i < 200 && done !== 1'b1; i++) @(posedge clk) #1;
        cmp(16'(done), 16'h0001, "done");
        cmp(mem[p + 16'h0001], cnt + 16'h0001, "count");
        cmp(mem[p + 16'h0002], np, "pointer");
        cmp(next_p, exp_next(intr, p, ret, cnt), "next");
        cmp(k[1] ? per_wdata : mem[w],
            exp_data(k, np, old, io_data), "data");
        cmp(16'(echo_cycles - e0),
            (intr && cnt == 16'hffff) ? 16'(AIOBT_IO_CYCLES) : 16'h0000, "notify");
        cmp({8'h00, per_dev}, {8'h00, dev}, "device");
    endtask : run_op
    task automatic final_report();
        $display("checked %0d bad %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    initial begin
        void'($urandom(32667));
        srst = 1'b1;
        start_valid = 1'b0;
        start = '0;
        mem_ack = 1'b0;
        mem_rdata = 16'h0000;
        arm = 1'b0;
        io_data = 16'h0000;
        repeat (20) @(posedge clk);
        #1;
        srst = 1'b0;
        cmp({14'h0, start_ready, echo_n}, 16'h0003, "reset idle");
        // each kind in line: mid-block, last unit with wrapping pointer, then random
        for (int k = 0; k < 4; k++) begin
            run_op(aiobt_kind_type'(k), 1'b0, 16'h9000, 16'hfff0, 16'h2345);
            run_op(aiobt_kind_type'(k), 1'b0, 16'h9100, 16'hffff, 16'hffff);
        end
        repeat (12) run_op(aiobt_kind_type'($urandom_range(3)), 1'b0,
            16'h9000 | (16'($urandom) & 16'h0ff0), 16'($urandom) | 16'h8000,
            16'($urandom) & 16'h7fff);
        $display("test inline done");
        // interrupt use: one execution per request until notify closes the block
        arm = 1'b1;
        @(posedge clk);
        #1;
        arm = 1'b0;
        n = 0;
        while (per_req === 1'b1 && n < 8) begin
            run_op(aiobt_kind_type'($urandom_range(3)), 1'b1, 16'ha000,
                16'hfffd + 16'(n), 16'h1000 + 16'(n));
            n++;
        end
        repeat (3) @(posedge clk);
        #1;
        cmp(16'(n), 16'h0003, "executions");
        cmp(16'(per_eob), 16'h0001, "end of block");
        cmp(eob_vec, 16'ha004, "end of block vector");
        $display("test interrupt done");
        final_report();
    end
endmodule : tb_auto_io_block_transfer
`default_nettype wire
